// >>> include/ogc_pkg.sv
/*
 Constants, register map and types for the output gating and calibration control block.
 Assumes an APB master on the same 25 MHz clock and a calibration engine that reports done pulses; success is read from lock.
*/
// Summary of operation
// - With keep-running 0 and squelch 0, outputs stay off until the first calibration has finished.
// - With keep-running 0 and squelch 1, outputs stay off until the first calibration that ends with lock.
// - With keep-running 1, outputs run at all times, even during calibration.
// - Output-to-output skew is kept across calibration only when squelch is 1.
// - Reset low puts all logic in a known state and all configuration registers to defaults.
// - Clock outputs stay disabled while reset is held.
// - Input-1 invalid pin drives input-1 bad status when enabled, else floats; polarity may invert it.
// - Input-2 invalid pin drives input-2 bad status when enabled, else floats; polarity may invert it.
// - Loss-of-lock is high while unlocked and low once locked.
package ogc_pkg;
   localparam logic [11:0] OGC_ADDR_CTRL = 12'h000;
   localparam logic [11:0] OGC_ADDR_STATUS = 12'h004;
   localparam logic [11:0] OGC_ADDR_IRQ = 12'h008;
   localparam logic [11:0] OGC_ADDR_MASK = 12'h00c;
   localparam logic [11:0] OGC_ADDR_CHANGE = 12'h010;
   // Control register fields
   localparam int OGC_CTRL_KEEP_RUN = 0;
   localparam int OGC_CTRL_SQUELCH = 1;
   localparam int OGC_CTRL_PIN1_EN = 2;
   localparam int OGC_CTRL_PIN2_EN = 3;
   localparam int OGC_CTRL_POL = 4;
   localparam int OGC_CTRL_START = 5;
   localparam logic [5:0] OGC_CTRL_RESET = 6'h00;
   // Status register fields
   localparam int OGC_ST_ENABLED = 0;
   localparam int OGC_ST_DONE = 1;
   localparam int OGC_ST_GOOD = 2;
   localparam int OGC_ST_LOL = 3;
   localparam int OGC_ST_SKEW = 4;
   localparam int OGC_ST_BUSY = 5;
   localparam int OGC_ST_PENDING = 6;
   // Interrupt bits
   localparam int OGC_IRQ_CAL_DONE = 0;
   localparam int OGC_IRQ_LOCK_LOST = 1;
   localparam int OGC_IRQ_BAD1 = 2;
   localparam int OGC_IRQ_BAD2 = 3;
   localparam int OGC_IRQ_W = 4;
   localparam logic [31:0] OGC_SLVERR_DATA = 32'h0000_0000;
   typedef enum logic [1:0] {OGC_IDLE, OGC_CAL} ogc_cal_t;
endpackage

// >>> include/ogc_flag_if.sv
/*
 Interface carrying the two calibration history flags from the tracker to the top.
 Assumes a single clock domain.
*/
`timescale 1ns/10ps
interface ogc_flag_if;
   logic done;
   logic good;
   modport tracker (output done, output good);
   modport user (input done, input good);
endinterface

// >>> hw/ogc_cal_track.sv
/*
 Calibration history tracker: remembers whether a calibration finished and whether one finished locked.
 Assumes done pulses from the calibration engine are one cycle wide.
*/
`timescale 1ns/10ps
module ogc_cal_track
   import ogc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic cal_done,
   input wire logic loss_of_lock,
   ogc_flag_if.tracker flags
);
   logic done;
   logic good;
   logic next_done;
   logic next_good;

   // Flags are sticky until reset; a locked finish counts as success
   always_comb
   begin
      next_done = done | cal_done;
      next_good = good | (cal_done & ~loss_of_lock);
   end

   // Reset restarts from "no calibration yet"
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         done <= 1'b0;
         good <= 1'b0;
      end
      else
      begin
         done <= next_done;
         good <= next_good;
      end
   end

   assign flags.done = done;
   assign flags.good = good;

   done_sticky_a: assert property (@(posedge clk) disable iff (!rst_b)
      cal_done |=> done) else $error("done flag missed a finish");
   good_needs_lock_a: assert property (@(posedge clk) disable iff (!rst_b)
      $rose(good) |-> $past(cal_done) && !$past(loss_of_lock)) else $error("good set without locked finish");
endmodule

// >>> hw/ogc_top.sv
/*
 Output gating around internal calibration, alarm pin drive and an APB register file with interrupts.
 Assumes APB on clk, a calibration engine that takes a start pulse and returns a done pulse, and
 lock/alarm inputs synchronous to clk.
*/
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/10ps
module ogc_top
   import ogc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cal_done,
   input wire logic pll_unlocked,
   input wire logic input1_bad_status,
   input wire logic input2_bad_status,
   output logic cal_start,
   output logic clock_output_enable,
   output logic skew_preserve,
   output logic loss_of_lock,
   output logic input1_invalid_pin_o,
   output logic input1_invalid_pin_oe,
   output logic input2_invalid_pin_o,
   output logic input2_invalid_pin_oe,
   output logic irq
);
   ogc_flag_if flags ();
   logic [5:0] ctrl;
   logic [OGC_IRQ_W-1:0] irq_st;
   logic [OGC_IRQ_W-1:0] irq_mask;
   logic change_pending;
   ogc_cal_t cal_state;
   logic lol_q;
   logic bad1_q;
   logic bad2_q;
   logic [5:0] next_ctrl;
   logic [OGC_IRQ_W-1:0] next_irq_st;
   logic [OGC_IRQ_W-1:0] next_irq_mask;
   logic next_change_pending;
   ogc_cal_t next_cal_state;
   logic next_cal_start;
   logic next_out_en;
   logic next_skew;
   logic next_pin1;
   logic next_pin2;
   logic next_irq;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic wr;
   logic rd;
   logic hit;
   logic [OGC_IRQ_W-1:0] events;

   ogc_cal_track u_track (
      .clk(clk),
      .rst_b(rst_b),
      .cal_done(cal_done),
      .loss_of_lock(pll_unlocked),
      .flags(flags.tracker)
   );

   // Access phase decode; slave answers one cycle after penable rises.
   // A write lands only at the edge that samples pready high, so the master sees it take effect there.
   assign wr = psel & penable & pwrite & pready;
   assign rd = psel & penable & ~pwrite & ~pready;
   assign hit = (paddr == OGC_ADDR_CTRL) | (paddr == OGC_ADDR_STATUS) | (paddr == OGC_ADDR_IRQ) |
                (paddr == OGC_ADDR_MASK) | (paddr == OGC_ADDR_CHANGE);
   // Alarms and loss of lock on rising edges only, cal_done taken as is; a falling alarm must not raise an interrupt
   assign events = {~bad2_q & input2_bad_status,
                    ~bad1_q & input1_bad_status,
                    pll_unlocked & ~lol_q, cal_done};

   // Register writes, sticky interrupts (set beats clear) and change tracking
   always_comb
   begin
      next_ctrl = ctrl;
      next_irq_mask = irq_mask;
      next_irq_st = irq_st;
      next_change_pending = change_pending;
      // Clear first so that a change noted as a calibration ends stays pending: that run began before it
      if (cal_done)
         next_change_pending = 1'b0;
      if (wr && paddr == OGC_ADDR_CTRL)
      begin
         next_ctrl = pwdata[5:0];
         // Changing keep-running takes effect at once and leaves a change pending until a calibration ends
         if (pwdata[OGC_CTRL_KEEP_RUN] != ctrl[OGC_CTRL_KEEP_RUN])
            next_change_pending = 1'b1;
      end
      if (wr && paddr == OGC_ADDR_CHANGE)
         next_change_pending = 1'b1;
      if (wr && paddr == OGC_ADDR_MASK)
         next_irq_mask = pwdata[OGC_IRQ_W-1:0];
      if (wr && paddr == OGC_ADDR_IRQ)
         next_irq_st = irq_st & ~pwdata[OGC_IRQ_W-1:0];
      next_irq_st = next_irq_st | events;
      next_ctrl[OGC_CTRL_START] = 1'b0;
   end

   // Calibration sequencer: one start pulse per software request made while idle
   always_comb
   begin
      next_cal_state = cal_state;
      next_cal_start = 1'b0;
      unique case (cal_state)
         OGC_IDLE:
            if (wr && paddr == OGC_ADDR_CTRL && pwdata[OGC_CTRL_START])
            begin
               next_cal_start = 1'b1;
               next_cal_state = OGC_CAL;
            end
         OGC_CAL:
            if (cal_done)
               next_cal_state = OGC_IDLE;
      endcase
   end

   // Output gating from the two settings and the two history flags
   always_comb
   begin
      if (ctrl[OGC_CTRL_KEEP_RUN])
         next_out_en = 1'b1;
      else if (ctrl[OGC_CTRL_SQUELCH])
         next_out_en = flags.good;
      else
         next_out_en = flags.done;
      next_skew = ctrl[OGC_CTRL_SQUELCH];
      // Polarity bit set inverts the default active-high alarm
      next_pin1 = input1_bad_status ^ ctrl[OGC_CTRL_POL];
      next_pin2 = input2_bad_status ^ ctrl[OGC_CTRL_POL];
      next_irq = |(next_irq_st & next_irq_mask);
   end

   // Read mux; unmapped addresses answer with an error
   always_comb
   begin
      next_prdata = prdata;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      if (psel && penable && !pready)
      begin
         next_pready = 1'b1;
         next_pslverr = ~hit;
         next_prdata = 32'h0000_0000;
         if (rd)
         begin
            unique case (paddr)
               OGC_ADDR_CTRL: next_prdata[4:0] = ctrl[4:0];
               OGC_ADDR_STATUS: next_prdata[6:0] = {change_pending, cal_state == OGC_CAL, skew_preserve,
                                                    lol_q, flags.good, flags.done, clock_output_enable};
               OGC_ADDR_IRQ: next_prdata[OGC_IRQ_W-1:0] = irq_st;
               OGC_ADDR_MASK: next_prdata[OGC_IRQ_W-1:0] = irq_mask;
               default: next_prdata = OGC_SLVERR_DATA;
            endcase
         end
      end
   end

   // All state and outputs registered; reset forces defaults, clock outputs off and loss-of-lock high
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ctrl <= OGC_CTRL_RESET;
         irq_st <= '0;
         irq_mask <= '0;
         change_pending <= 1'b0;
         cal_state <= OGC_IDLE;
         lol_q <= 1'b1;
         bad1_q <= 1'b0;
         bad2_q <= 1'b0;
         cal_start <= 1'b0;
         clock_output_enable <= 1'b0;
         skew_preserve <= 1'b0;
         loss_of_lock <= 1'b1;
         input1_invalid_pin_o <= 1'b0;
         input1_invalid_pin_oe <= 1'b0;
         input2_invalid_pin_o <= 1'b0;
         input2_invalid_pin_oe <= 1'b0;
         irq <= 1'b0;
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
      else
      begin
         ctrl <= next_ctrl;
         irq_st <= next_irq_st;
         irq_mask <= next_irq_mask;
         change_pending <= next_change_pending;
         cal_state <= next_cal_state;
         lol_q <= pll_unlocked;
         bad1_q <= input1_bad_status;
         bad2_q <= input2_bad_status;
         cal_start <= next_cal_start;
         clock_output_enable <= next_out_en;
         skew_preserve <= next_skew;
         loss_of_lock <= pll_unlocked;
         input1_invalid_pin_o <= next_pin1;
         input1_invalid_pin_oe <= ctrl[OGC_CTRL_PIN1_EN];
         input2_invalid_pin_o <= next_pin2;
         input2_invalid_pin_oe <= ctrl[OGC_CTRL_PIN2_EN];
         irq <= next_irq;
         prdata <= next_prdata;
         pready <= next_pready;
         pslverr <= next_pslverr;
      end
   end

   keep_running_a: assert property (@(posedge clk) disable iff (!rst_b)
      ctrl[OGC_CTRL_KEEP_RUN] |=> clock_output_enable) else $error("outputs off with keep-running set");
   squelch_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      !ctrl[OGC_CTRL_KEEP_RUN] && ctrl[OGC_CTRL_SQUELCH] |=> clock_output_enable == $past(flags.good))
      else $error("squelch gating wrong");
   first_cal_a: assert property (@(posedge clk) disable iff (!rst_b)
      !ctrl[OGC_CTRL_KEEP_RUN] && !ctrl[OGC_CTRL_SQUELCH] |=> clock_output_enable == $past(flags.done))
      else $error("first-calibration gating wrong");
   skew_flag_a: assert property (@(posedge clk) disable iff (!rst_b)
      rst_b |=> skew_preserve == $past(ctrl[OGC_CTRL_SQUELCH])) else $error("skew flag wrong");
   reset_off_a: assert property (@(posedge clk)
      !rst_b |=> !clock_output_enable) else $error("outputs on after reset");
   reset_ctrl_a: assert property (@(posedge clk)
      !rst_b |=> ctrl == OGC_CTRL_RESET && irq_mask == '0) else $error("config not defaulted");
   pin1_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
      rst_b |=> input1_invalid_pin_oe == $past(ctrl[OGC_CTRL_PIN1_EN]) &&
      input1_invalid_pin_o == ($past(input1_bad_status) ^ $past(ctrl[OGC_CTRL_POL]))) else $error("pin1 wrong");
   pin2_drive_a: assert property (@(posedge clk) disable iff (!rst_b)
      rst_b |=> input2_invalid_pin_oe == $past(ctrl[OGC_CTRL_PIN2_EN]) &&
      input2_invalid_pin_o == ($past(input2_bad_status) ^ $past(ctrl[OGC_CTRL_POL]))) else $error("pin2 wrong");
   lol_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
      rst_b |=> loss_of_lock == $past(pll_unlocked)) else $error("loss of lock not followed");
   apb_answer_a: assert property (@(posedge clk) disable iff (!rst_b)
      psel && penable && !pready |=> pready ##1 !pready) else $error("apb answer timing");

   cal_seen_c: cover property (@(posedge clk) disable iff (!rst_b) cal_start ##[1:50] cal_done);
   squelch_release_c: cover property (@(posedge clk) disable iff (!rst_b)
      ctrl[OGC_CTRL_SQUELCH] && $rose(clock_output_enable));
   irq_c: cover property (@(posedge clk) disable iff (!rst_b) $rose(irq));
endmodule

// >>> tb/tb.sv
/*
 Self-checking bench for the output gating block: APB master, calibration engine stand-in and alarm inputs.
 Assumes one 25 MHz clock and the one-wait-state APB answer of the register file.
*/
`timescale 1ns/10ps
module tb;
   import ogc_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, cal_start, clock_output_enable, skew_preserve, loss_of_lock, irq;
   logic cal_done = 1'b0, pll_unlocked = 1'b1, input1_bad_status = 1'b0, input2_bad_status = 1'b0;
   logic p1_o, p1_oe, p2_o, p2_oe;
   int num_errors = 0;
   int n_compared = 0;
   // Reference model state
   int keep, sq, done, good;
   logic [31:0] rv;
   logic re;
   ogc_top i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cal_done(cal_done),
      .pll_unlocked(pll_unlocked), .input1_bad_status(input1_bad_status), .input2_bad_status(input2_bad_status),
      .cal_start(cal_start), .clock_output_enable(clock_output_enable), .skew_preserve(skew_preserve),
      .loss_of_lock(loss_of_lock), .input1_invalid_pin_o(p1_o), .input1_invalid_pin_oe(p1_oe),
      .input2_invalid_pin_o(p2_o), .input2_invalid_pin_oe(p2_oe), .irq(irq));
   // 40 ns period
   always #20 clk = ~clk;
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Request held from setup until the edge that samples pready high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
      output logic err);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // pready is looked at on the rising edge; the answer is taken and the request dropped there
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
      begin
         num_errors++;
         stop_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic do_reset;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("oe_in_reset", clock_output_enable, 1'b0);
      chk("lol_in_reset", loss_of_lock, 1'b1);
      // Released on a rising edge, so three edges see reset low
      @(posedge clk);
      rst_b <= 1'b1;
      done = 0;
      good = 0;
      keep = 0;
      sq = 0;
   endtask
   function automatic logic exp_en();
      return (keep != 0) || (sq != 0 ? good != 0 : done != 0);
   endfunction
   // One calibration; lk selects whether the loop is locked when it ends
   task automatic cal(input logic lk, input logic [31:0] ctrl);
      int n;
      n = 0;
      @(posedge clk);
      pll_unlocked <= !lk;
      apb(1'b1, OGC_ADDR_CTRL, ctrl | 32'h20, rv, re);
      do
      begin
         @(negedge clk);
         n++;
      end
      while (cal_start !== 1'b1 && n < 20);
      chk("cal_start", cal_start, 1'b1);
      if (cal_start !== 1'b1)
         stop_test();
      chk("lol_level", loss_of_lock, !lk);
      chk("oe_during_cal", clock_output_enable, exp_en());
      @(posedge clk);
      cal_done <= 1'b1;
      @(posedge clk);
      cal_done <= 1'b0;
      done = 1;
      if (lk) good = 1;
      repeat (3) @(negedge clk);
      chk("oe_after_cal", clock_output_enable, exp_en());
   endtask
   initial
   begin
      void'($urandom(36344));
      // Every keep-running / squelch combination, from reset each time
      for (int m = 0; m < 4; m++)
      begin
         do_reset();
         apb(1'b0, OGC_ADDR_CTRL, 32'h0, rv, re);
         chk("ctrl_reset", rv, 32'h0);
         apb(1'b0, OGC_ADDR_MASK, 32'h0, rv, re);
         chk("mask_reset", rv, 32'h0);
         chk("oe_no_cal", clock_output_enable, 1'b0);
         keep = m & 1;
         sq = m >> 1;
         apb(1'b1, OGC_ADDR_CTRL, m, rv, re);
         repeat (2) @(negedge clk);
         chk("oe_mode", clock_output_enable, exp_en());
         chk("skew", skew_preserve, sq);
         cal(1'b0, m);
         cal(1'b1, m);
         $display("test mode %0d done", m);
      end
      // Alarm pins: drive, tristate and polarity with random inputs
      for (int i = 0; i < 16; i++)
      begin
         logic [4:0] c;
         c = $urandom() & 5'h1c;
         @(posedge clk);
         input1_bad_status <= $urandom() & 1;
         input2_bad_status <= $urandom() & 1;
         apb(1'b1, OGC_ADDR_CTRL, c, rv, re);
         apb(1'b0, OGC_ADDR_CTRL, 32'h0, rv, re);
         chk("ctrl_rb", rv, c);
         // Pins are registered; look at them once settled
         @(negedge clk);
         chk("pin1_oe", p1_oe, c[2]);
         chk("pin1", p1_o, input1_bad_status ^ c[4]);
         chk("pin2_oe", p2_oe, c[3]);
         chk("pin2", p2_o, input2_bad_status ^ c[4]);
      end
      $display("test alarm pins done");
      // Interrupt: raise, mask, clear
      keep = 0; sq = 0;
      apb(1'b1, OGC_ADDR_IRQ, 32'hf, rv, re);
      apb(1'b1, OGC_ADDR_MASK, 32'h0, rv, re);
      cal(1'b1, 32'h0);
      chk("irq_masked", irq, 1'b0);
      apb(1'b1, OGC_ADDR_MASK, 32'h1, rv, re);
      @(negedge clk);
      chk("irq_on", irq, 1'b1);
      apb(1'b0, OGC_ADDR_IRQ, 32'h0, rv, re);
      chk("irq_stat", rv & 32'h1, 32'h1);
      apb(1'b1, OGC_ADDR_IRQ, 32'h1, rv, re);
      @(negedge clk);
      chk("irq_clr", irq, 1'b0);
      apb(1'b0, 12'h020, 32'h0, rv, re);
      chk("unmapped_err", re, 1'b1);
      chk("unmapped_data", rv, 32'h0);
      $display("test interrupt done");
      // Host duty: a noted change, or a keep-running flip, stays pending until the next calibration
      apb(1'b1, OGC_ADDR_CHANGE, 32'h1, rv, re);
      apb(1'b0, OGC_ADDR_STATUS, 32'h0, rv, re);
      chk("pending_set", rv[OGC_ST_PENDING], 1'b1);
      cal(1'b1, 32'h0);
      apb(1'b0, OGC_ADDR_STATUS, 32'h0, rv, re);
      chk("pending_clr", rv[OGC_ST_PENDING], 1'b0);
      keep = 1;
      apb(1'b1, OGC_ADDR_CTRL, 32'h1, rv, re);
      apb(1'b0, OGC_ADDR_STATUS, 32'h0, rv, re);
      chk("pending_keep", rv[OGC_ST_PENDING], 1'b1);
      chk("status_oe", rv[OGC_ST_ENABLED], 1'b1);
      cal(1'b1, 32'h1);
      apb(1'b0, OGC_ADDR_STATUS, 32'h0, rv, re);
      chk("pending_done", rv[OGC_ST_PENDING], 1'b0);
      $display("test change pending done");
      stop_test();
   end
   // Watchdog well beyond the few hundred cycles the tests take
   initial
   begin
      #2000000;
      num_errors++;
      stop_test();
   end
endmodule
